// file: hw/cms_pkg.sv
// shared constants and types for the card mode and voltage setup link
package cms_pkg;
	localparam int CMD_W = 6;
	localparam int ARG_W = 32;
	localparam int RSP_W = 32;
	localparam int CID_W_DEF = 16;
	// command indices
	localparam logic [5:0] CMD_SOFT_RESET = 6'h00;
	localparam logic [5:0] CMD_OP_COND = 6'h01;
	localparam logic [5:0] CMD_ID_BCAST = 6'h02;
	localparam logic [5:0] CMD_ASSIGN_ADDR = 6'h03;
	localparam logic [5:0] CMD_SET_DRIVER = 6'h04;
	localparam logic [5:0] CMD_SELECT = 6'h07;
	localparam logic [5:0] CMD_STOP = 6'h0c;
	localparam logic [5:0] CMD_STATUS = 6'h0d;
	localparam logic [5:0] CMD_GO_INACTIVE = 6'h0f;
	localparam logic [5:0] CMD_READ_BLK = 6'h11;
	localparam logic [5:0] CMD_WRITE_BLK = 6'h18;
	localparam logic [5:0] CMD_IRQ_MODE = 6'h28;
	// argument and response fields
	localparam int ADDR_LSB = 16;
	localparam int WIN_W = 24;
	localparam int READY_BIT = 31;
	localparam logic [15:0] RCA_DEFAULT = 16'h0001;
	localparam logic [15:0] RCA_ALL = 16'h0000;
	localparam logic [15:0] DSR_DEFAULT = 16'h0000;
	localparam logic [23:0] OCR_DEFAULT = 24'hff8000;
	// arbitrary id number, any unique value will do
	localparam logic [15:0] CID_DEFAULT = 16'h5a3c;
	// timing counts at 50 MHz
	localparam int CLK_MHZ = 50;
	localparam int BUSY_US = 10;
	localparam int BUSY_CYC = BUSY_US * CLK_MHZ;
	localparam int PRG_CYC = 8;
	localparam int RSP_TIMEOUT = 4;
	// card states, one-hot
	typedef enum logic [10:0] {
		ST_INACTIVE = 11'h001,
		ST_IDLE = 11'h002,
		ST_READY = 11'h004,
		ST_IDENT = 11'h008,
		ST_STBY = 11'h010,
		ST_TRAN = 11'h020,
		ST_DATA = 11'h040,
		ST_RCV = 11'h080,
		ST_PRG = 11'h100,
		ST_DIS = 11'h200,
		ST_IRQ = 11'h400
	} cms_state_t;
	function automatic logic cms_is_open_drain(input cms_state_t s);
		return (s == ST_INACTIVE) || (s == ST_IDLE) || (s == ST_READY) || (s == ST_IDENT);
	endfunction
endpackage

// file: hw/cms_link_if.sv
// command link between the bus host and one card
`timescale 1ns/100ps
interface cms_link_if;
	import cms_pkg::*;
	// host side
	logic cmd_stb;
	logic [CMD_W-1:0] cmd_idx;
	logic [ARG_W-1:0] cmd_arg;
	logic alt_sel;
	// card side
	logic [RSP_W-1:0] rsp_out;
	logic rsp_oe;
	logic id_out;
	logic id_oe;
	// resolved open-drain lines with pull-up
	logic [RSP_W-1:0] rsp_line;
	logic id_line;
	assign rsp_line = rsp_oe ? rsp_out : {RSP_W{1'b1}};
	assign id_line = id_oe ? id_out : 1'b1;
	modport host (output cmd_stb, cmd_idx, cmd_arg, alt_sel, input rsp_oe, rsp_line, id_oe, id_line);
	modport card (input cmd_stb, cmd_idx, cmd_arg, alt_sel, id_line, output rsp_out, rsp_oe,
		id_out, id_oe);
endinterface

// file: hw/cms_card.sv
// card end: operation modes, reset defaults, voltage setup, identification
`timescale 1ns/100ps
module cms_card
	import cms_pkg::*;
#(
	parameter int CID_W = CID_W_DEF,
	parameter int BUSY_CYCLES = BUSY_CYC,
	parameter logic [23:0] OCR_RANGE = OCR_DEFAULT,
	parameter bit FULL_RANGE = 1'b0,
	parameter logic [CID_W_DEF-1:0] CID_VALUE = CID_DEFAULT
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic ce,
	// link
	cms_link_if.card link,
	// card internals
	input wire logic irq_event,
	output cms_state_t state_ff,
	output logic push_pull_ff,
	output logic alt_mode_ff,
	output logic [15:0] rca_ff,
	output logic [15:0] dsr_ff,
	output logic [23:0] window_ff
);
	cms_state_t nxt_state;
	logic [31:0] busy_cnt_ff;
	logic [7:0] id_bit_ff;
	logic [CID_W-1:0] id_shift_ff;
	logic id_active_ff;
	logic [3:0] prg_cnt_ff;
	logic [RSP_W-1:0] rsp_out_ff;
	logic rsp_oe_ff;
	logic id_out_ff;
	logic id_oe_ff;
	logic own_addr;
	logic soft_reset;
	logic busy;
	logic [23:0] cmd_win;
	logic win_bad;
	logic id_done;
	logic id_lost;
	logic send_rsp;
	logic [RSP_W-1:0] rsp_val;

	assign link.rsp_out = rsp_out_ff;
	assign link.rsp_oe = rsp_oe_ff;
	assign link.id_out = id_out_ff;
	assign link.id_oe = id_oe_ff;

	assign own_addr = link.cmd_arg[ARG_W-1:ADDR_LSB] == rca_ff;
	assign busy = busy_cnt_ff != 32'h0000_0000;
	assign cmd_win = link.cmd_arg[WIN_W-1:0];
	// window outside the card range, unless full-range card ignores it
	assign win_bad = !FULL_RANGE && (cmd_win != 24'h000000) && ((cmd_win & OCR_RANGE) == 24'h000000);
	// software reset: refused while inactive unless it selects alternate mode
	assign soft_reset = link.cmd_stb && link.cmd_idx == CMD_SOFT_RESET &&
		(state_ff != ST_INACTIVE || link.alt_sel);
	assign id_lost = id_active_ff && (link.id_line != id_out_ff);
	assign id_done = id_active_ff && !id_lost && id_bit_ff == 8'(CID_W - 1);

	// state transitions
	always_comb begin
		nxt_state = state_ff;
		send_rsp = 1'b0;
		rsp_val = {RSP_W{1'b0}};
		if (soft_reset) begin
			nxt_state = ST_IDLE;
		end else if (state_ff == ST_IRQ && (link.cmd_stb || irq_event)) begin
			nxt_state = ST_STBY;
			send_rsp = irq_event && !link.cmd_stb;
			rsp_val = {rca_ff, 16'h0000};
		end else if (id_done) begin
			nxt_state = ST_IDENT;
		end else if (state_ff == ST_PRG && prg_cnt_ff == 4'(PRG_CYC - 1)) begin
			nxt_state = ST_TRAN;
		end else if (state_ff == ST_DIS && prg_cnt_ff == 4'(PRG_CYC - 1)) begin
			nxt_state = ST_STBY;
		end else if (link.cmd_stb && !alt_mode_ff) begin
			case (link.cmd_idx)
				CMD_OP_COND: begin
					if (state_ff == ST_IDLE || state_ff == ST_READY) begin
						if (win_bad) begin
							nxt_state = ST_INACTIVE;
						end else begin
							send_rsp = 1'b1;
							// ready bit low while busy dominates the wired-AND
							rsp_val = {!busy, 7'h00, OCR_RANGE};
							if (!busy && cmd_win != 24'h000000) begin
								nxt_state = ST_READY;
							end
						end
					end
				end
				CMD_ASSIGN_ADDR: begin
					if (state_ff == ST_IDENT) begin
						nxt_state = ST_STBY;
						send_rsp = 1'b1;
						rsp_val = {link.cmd_arg[ARG_W-1:ADDR_LSB], 16'h0000};
					end
				end
				CMD_SELECT: begin
					if (own_addr && state_ff == ST_STBY) begin
						nxt_state = ST_TRAN;
						send_rsp = 1'b1;
						rsp_val = {21'h000000, state_ff};
					end else if (own_addr && state_ff == ST_PRG) begin
						nxt_state = ST_DIS;
					end else if (state_ff == ST_TRAN || state_ff == ST_DATA) begin
						nxt_state = ST_STBY;
					end else if (state_ff == ST_DIS && own_addr) begin
						nxt_state = ST_PRG;
					end
				end
				CMD_STATUS: begin
					if (own_addr && !cms_is_open_drain(state_ff)) begin
						send_rsp = 1'b1;
						rsp_val = {21'h000000, state_ff};
					end
				end
				CMD_GO_INACTIVE: begin
					if (own_addr && !cms_is_open_drain(state_ff)) begin
						nxt_state = ST_INACTIVE;
					end
				end
				CMD_READ_BLK: begin
					if (state_ff == ST_TRAN) begin
						nxt_state = ST_DATA;
					end
				end
				CMD_WRITE_BLK: begin
					if (state_ff == ST_TRAN) begin
						nxt_state = ST_RCV;
					end
				end
				CMD_STOP: begin
					if (state_ff == ST_DATA) begin
						nxt_state = ST_TRAN;
					end else if (state_ff == ST_RCV) begin
						nxt_state = ST_PRG;
					end
				end
				CMD_IRQ_MODE: begin
					if (state_ff == ST_STBY) begin
						nxt_state = ST_IRQ;
					end
				end
				default: begin
					nxt_state = state_ff;
				end
			endcase
		end
	end

	// state register, power-on gives idle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ST_IDLE;
		end else if (ce) begin
			state_ff <= nxt_state;
		end
	end

	// bus drive mode follows state
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			push_pull_ff <= 1'b0;
		end else if (ce) begin
			push_pull_ff <= !cms_is_open_drain(nxt_state);
		end
	end

	// native or alternate serial mode
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			alt_mode_ff <= 1'b0;
		end else if (ce && soft_reset) begin
			alt_mode_ff <= link.alt_sel;
		end
	end

	// address, driver stage and voltage window
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rca_ff <= RCA_DEFAULT;
			dsr_ff <= DSR_DEFAULT;
			window_ff <= 24'h000000;
		end else if (ce) begin
			if (soft_reset) begin
				rca_ff <= RCA_DEFAULT;
				dsr_ff <= DSR_DEFAULT;
				window_ff <= 24'h000000;
			end else if (link.cmd_stb && !alt_mode_ff) begin
				if (link.cmd_idx == CMD_ASSIGN_ADDR && state_ff == ST_IDENT) begin
					rca_ff <= link.cmd_arg[ARG_W-1:ADDR_LSB];
				end
				if (link.cmd_idx == CMD_SET_DRIVER && state_ff == ST_STBY) begin
					dsr_ff <= link.cmd_arg[ARG_W-1:ADDR_LSB];
				end
				// first window accepted sticks; later changes ignored
				if (nxt_state == ST_READY && window_ff == 24'h000000) begin
					window_ff <= cmd_win;
				end
			end
		end
	end

	// power-up and reset busy time
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_cnt_ff <= 32'(BUSY_CYCLES);
		end else if (ce) begin
			if (soft_reset) begin
				busy_cnt_ff <= 32'(BUSY_CYCLES);
			end else if (busy) begin
				busy_cnt_ff <= busy_cnt_ff - 32'h0000_0001;
			end
		end
	end

	// programming and disconnect completion timer
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prg_cnt_ff <= 4'h0;
		end else if (ce) begin
			if (state_ff != nxt_state || (state_ff != ST_PRG && state_ff != ST_DIS)) begin
				prg_cnt_ff <= 4'h0;
			end else begin
				prg_cnt_ff <= prg_cnt_ff + 4'h1;
			end
		end
	end

	// response on command line only, one cycle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rsp_out_ff <= {RSP_W{1'b1}};
			rsp_oe_ff <= 1'b0;
		end else if (ce) begin
			rsp_oe_ff <= send_rsp && !soft_reset;
			rsp_out_ff <= send_rsp ? rsp_val : {RSP_W{1'b1}};
		end
	end

	// identification number sent msb first, compared with the line
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			id_active_ff <= 1'b0;
			id_bit_ff <= 8'h00;
			id_shift_ff <= {CID_W{1'b0}};
			id_out_ff <= 1'b1;
			id_oe_ff <= 1'b0;
		end else if (ce) begin
			if (soft_reset || id_lost || id_done) begin
				id_active_ff <= 1'b0;
				id_oe_ff <= 1'b0;
				id_out_ff <= 1'b1;
			end else if (link.cmd_stb && link.cmd_idx == CMD_ID_BCAST && state_ff == ST_READY &&
				!alt_mode_ff) begin
				id_active_ff <= 1'b1;
				id_bit_ff <= 8'h00;
				id_out_ff <= CID_VALUE[CID_W-1];
				id_shift_ff <= {CID_VALUE[CID_W-2:0], 1'b0};
				id_oe_ff <= 1'b1;
			end else if (id_active_ff) begin
				id_bit_ff <= id_bit_ff + 8'h01;
				id_out_ff <= id_shift_ff[CID_W-1];
				id_shift_ff <= {id_shift_ff[CID_W-2:0], 1'b0};
			end
		end
	end
endmodule

// file: hw/cms_host.sv
// host end: sole bus master, mode tracking and voltage negotiation
`timescale 1ns/100ps
module cms_host
	import cms_pkg::*;
#(
	parameter int CID_W = CID_W_DEF
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic ce,
	// user requests
	input wire logic req_valid,
	input wire logic [CMD_W-1:0] req_idx,
	input wire logic [ARG_W-1:0] req_arg,
	input wire logic req_alt,
	output logic req_ready_ff,
	// user answers
	output logic done_ff,
	output logic done_rsp_ff,
	output logic [RSP_W-1:0] done_data_ff,
	output logic ident_mode_ff,
	output logic irq_mode_ff,
	// link
	cms_link_if.host link
);
	typedef enum logic [2:0] {
		HS_IDLE = 3'h1,
		HS_WAIT = 3'h2,
		HS_IDRX = 3'h4
	} cms_hstate_t;
	cms_hstate_t hst_ff;
	logic cmd_stb_ff;
	logic [CMD_W-1:0] cmd_idx_ff;
	logic [ARG_W-1:0] cmd_arg_ff;
	logic alt_sel_ff;
	logic [7:0] wait_ff;
	logic [23:0] locked_win_ff;
	logic [CID_W-1:0] cid_ff;
	logic [7:0] bits_ff;
	logic retry;
	logic [ARG_W-1:0] send_arg;

	assign link.cmd_stb = cmd_stb_ff;
	assign link.cmd_idx = cmd_idx_ff;
	assign link.cmd_arg = cmd_arg_ff;
	assign link.alt_sel = alt_sel_ff;

	// busy answer to the condition command forces a reissue
	assign retry = link.rsp_oe && cmd_idx_ff == CMD_OP_COND && !link.rsp_line[READY_BIT];
	// window held once chosen; poll without window passes
	assign send_arg = (req_idx == CMD_OP_COND && locked_win_ff != 24'h000000 &&
		req_arg[WIN_W-1:0] != 24'h000000) ? {req_arg[ARG_W-1:WIN_W], locked_win_ff} : req_arg;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			hst_ff <= HS_IDLE;
			cmd_stb_ff <= 1'b0;
			cmd_idx_ff <= 6'h00;
			cmd_arg_ff <= 32'h0000_0000;
			alt_sel_ff <= 1'b0;
			wait_ff <= 8'h00;
			req_ready_ff <= 1'b1;
			done_ff <= 1'b0;
			done_rsp_ff <= 1'b0;
			done_data_ff <= 32'h0000_0000;
			bits_ff <= 8'h00;
			cid_ff <= {CID_W{1'b0}};
		end else if (ce) begin
			cmd_stb_ff <= 1'b0;
			done_ff <= 1'b0;
			case (hst_ff)
				HS_IDLE: begin
					if (req_valid) begin
						cmd_stb_ff <= 1'b1;
						cmd_idx_ff <= req_idx;
						cmd_arg_ff <= send_arg;
						alt_sel_ff <= req_alt;
						wait_ff <= 8'h00;
						bits_ff <= 8'h00;
						req_ready_ff <= 1'b0;
						hst_ff <= (req_idx == CMD_ID_BCAST) ? HS_IDRX : HS_WAIT;
					end
				end
				HS_WAIT: begin
					wait_ff <= wait_ff + 8'h01;
					if (retry) begin
						cmd_stb_ff <= 1'b1;
						wait_ff <= 8'h00;
					end else if (link.rsp_oe || (wait_ff == 8'(RSP_TIMEOUT) &&
						cmd_idx_ff != CMD_IRQ_MODE)) begin
						done_ff <= 1'b1;
						done_rsp_ff <= link.rsp_oe;
						done_data_ff <= link.rsp_line;
						req_ready_ff <= 1'b1;
						hst_ff <= HS_IDLE;
					end else if (cmd_idx_ff == CMD_IRQ_MODE && req_valid) begin
						// user command aborts waiting for a service request
						done_ff <= 1'b1;
						done_rsp_ff <= 1'b0;
						req_ready_ff <= 1'b1;
						hst_ff <= HS_IDLE;
					end
				end
				HS_IDRX: begin
					wait_ff <= wait_ff + 8'h01;
					if (link.id_oe) begin
						cid_ff <= {cid_ff[CID_W-2:0], link.id_line};
						bits_ff <= bits_ff + 8'h01;
					end
					if (bits_ff == 8'(CID_W) || (bits_ff == 8'h00 && wait_ff == 8'(RSP_TIMEOUT))) begin
						done_ff <= 1'b1;
						done_rsp_ff <= bits_ff != 8'h00;
						done_data_ff <= 32'(cid_ff);
						req_ready_ff <= 1'b1;
						hst_ff <= HS_IDLE;
					end
				end
				default: begin
					hst_ff <= HS_IDLE;
				end
			endcase
		end
	end

	// operation mode and voltage window tracking
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ident_mode_ff <= 1'b1;
			irq_mode_ff <= 1'b0;
			locked_win_ff <= 24'h000000;
		end else if (ce) begin
			if (hst_ff == HS_IDLE && req_valid) begin
				if (req_idx == CMD_SOFT_RESET) begin
					locked_win_ff <= 24'h000000;
				end else if (req_idx == CMD_OP_COND && locked_win_ff == 24'h000000) begin
					locked_win_ff <= req_arg[WIN_W-1:0];
				end
				if (req_idx == CMD_SOFT_RESET || req_idx == CMD_OP_COND || req_idx == CMD_ID_BCAST) begin
					ident_mode_ff <= 1'b1;
				end
				irq_mode_ff <= req_idx == CMD_IRQ_MODE;
			end else if (hst_ff == HS_IDRX && bits_ff == 8'h00 && wait_ff == 8'(RSP_TIMEOUT)) begin
				ident_mode_ff <= 1'b0;
			end else if (hst_ff == HS_WAIT && (link.rsp_oe || req_valid)) begin
				irq_mode_ff <= 1'b0;
			end
		end
	end
endmodule

// file: tb/cms_link_sva.sv
// link checker for the card mode and voltage setup pair
`timescale 1ns/100ps
module cms_link_sva
	import cms_pkg::*;
#(
	parameter int CID_W = CID_W_DEF,
	parameter logic [23:0] OCR_RANGE = OCR_DEFAULT
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// host to card
	input wire logic cmd_stb,
	input wire logic [CMD_W-1:0] cmd_idx,
	input wire logic [ARG_W-1:0] cmd_arg,
	input wire logic alt_sel,
	// card to host
	input wire logic [RSP_W-1:0] rsp_out,
	input wire logic rsp_oe,
	input wire logic id_out,
	input wire logic id_oe,
	input wire logic [RSP_W-1:0] rsp_line,
	input wire logic id_line
);
	logic [7:0] id_cnt_ff;
	logic irq_wait_ff;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// length of the running id burst
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			id_cnt_ff <= 8'h00;
		end else if (id_oe) begin
			id_cnt_ff <= id_cnt_ff + 8'h01;
		end else begin
			id_cnt_ff <= 8'h00;
		end
	end
	// last command put cards into wait for service
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_wait_ff <= 1'b0;
		end else if (cmd_stb) begin
			irq_wait_ff <= (cmd_idx == CMD_IRQ_MODE);
		end
	end
	a_rsp_after_cmd: assert property (rsp_oe |-> $past(cmd_stb) || irq_wait_ff)
		else $error("response without a command");
	a_rsp_one_cycle: assert property (rsp_oe |=> !rsp_oe)
		else $error("response held too long");
	// a busy condition answer allows the reissue right after it
	a_host_waits: assert property (cmd_stb |=> !cmd_stb ##1
		(!cmd_stb || $past(rsp_oe && !rsp_line[READY_BIT])))
		else $error("commands too close");
	a_lines_exclusive: assert property (!(rsp_oe && id_oe))
		else $error("response and id driven together");
	a_id_start: assert property ($rose(id_oe)
		|-> $past(cmd_stb) && $past(cmd_idx) == CMD_ID_BCAST)
		else $error("id burst without broadcast");
	a_id_length: assert property ($fell(id_oe) |-> id_cnt_ff == CID_W)
		else $error("id burst length wrong");
	a_opcond_range: assert property (rsp_oe && $past(cmd_stb)
		&& $past(cmd_idx) == CMD_OP_COND
		|-> rsp_out[23:0] == OCR_RANGE && rsp_out[30:24] == 7'h00)
		else $error("condition response wrong");
	a_assign_echo: assert property (rsp_oe && $past(cmd_stb)
		&& $past(cmd_idx) == CMD_ASSIGN_ADDR
		|-> rsp_out[31:16] == $past(cmd_arg[ARG_W-1:ADDR_LSB]) && rsp_out[15:0] == 16'h0000)
		else $error("address response wrong");
	a_reset_silent: assert property (cmd_stb && cmd_idx == CMD_SOFT_RESET
		|=> !rsp_oe && !id_oe ##1 !rsp_oe)
		else $error("soft reset answered");
	a_bcast_silent: assert property (cmd_stb && cmd_idx == CMD_SET_DRIVER |=> !rsp_oe)
		else $error("driver broadcast answered");
endmodule

// file: tb/test_card_mode_and_voltage_setup.sv
// self-checking bench for host and card ends
`timescale 1ns/100ps
module test_card_mode_and_voltage_setup
	import cms_pkg::*;
;
	localparam int BUSY_SIM = 40;
	localparam logic [15:0] MY_RCA = 16'h1234;
	localparam logic [23:0] BAD_WIN = 24'h00007f;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic req_valid = 1'b0;
	logic [CMD_W-1:0] req_idx = 6'h00;
	logic [ARG_W-1:0] req_arg = 32'h00000000;
	logic req_alt = 1'b0;
	logic req_ready_ff, done_ff, done_rsp_ff, ident_mode_ff, irq_mode_ff;
	logic [RSP_W-1:0] done_data_ff;
	cms_state_t state_ff;
	logic push_pull_ff, alt_mode_ff;
	logic [15:0] rca_ff, dsr_ff;
	logic [23:0] window_ff;
	logic [15:0] id_shift = 16'h0000;
	logic irq_event = 1'b0;
	logic busy_seen = 1'b0;
	int n_errors = 0;
	int num_checks = 0;
	int i;
	cms_link_if link();
	cms_card #(.BUSY_CYCLES(BUSY_SIM)) cms_card_inst (.core_clk(core_clk), .arst_n(arst_n),
		.ce(1'b1), .link(link), .irq_event(irq_event), .state_ff(state_ff),
		.push_pull_ff(push_pull_ff), .alt_mode_ff(alt_mode_ff), .rca_ff(rca_ff),
		.dsr_ff(dsr_ff), .window_ff(window_ff));
	cms_host cms_host_inst (.core_clk(core_clk), .arst_n(arst_n), .ce(1'b1),
		.req_valid(req_valid), .req_idx(req_idx), .req_arg(req_arg), .req_alt(req_alt),
		.req_ready_ff(req_ready_ff), .done_ff(done_ff), .done_rsp_ff(done_rsp_ff),
		.done_data_ff(done_data_ff), .ident_mode_ff(ident_mode_ff),
		.irq_mode_ff(irq_mode_ff), .link(link));
	cms_link_sva cms_link_sva_inst (.core_clk(core_clk), .arst_n(arst_n),
		.cmd_stb(link.cmd_stb), .cmd_idx(link.cmd_idx), .cmd_arg(link.cmd_arg),
		.alt_sel(link.alt_sel), .rsp_out(link.rsp_out), .rsp_oe(link.rsp_oe),
		.id_out(link.id_out), .id_oe(link.id_oe), .rsp_line(link.rsp_line),
		.id_line(link.id_line));
	always #10 core_clk = ~core_clk;
	// id bits as seen on the wire, busy answers to the condition command
	always @(posedge core_clk) begin
		if (link.id_oe === 1'b1) begin
			id_shift <= {id_shift[14:0], link.id_line};
		end
		if (link.rsp_oe === 1'b1 && link.cmd_idx == CMD_OP_COND &&
			link.rsp_line[READY_BIT] === 1'b0) begin
			busy_seen <= 1'b1;
		end
	end
	// service event raised while the card waits for one
	always @(posedge core_clk) begin
		irq_event <= state_ff === ST_IRQ;
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic send(input logic [5:0] idx, input logic [31:0] arg, input logic alt);
		int n;
		@(posedge core_clk);
		req_valid <= 1'b1;
		req_idx <= idx;
		req_arg <= arg;
		req_alt <= alt;
		@(posedge core_clk);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (done_ff !== 1'b1 && n < 40);
		chk("done", 32'h1, {31'h0, done_ff});
		chk("req_ready", 32'h1, {31'h0, req_ready_ff});
	endtask
	task automatic rst();
		@(posedge core_clk);
		arst_n <= 1'b0;
		repeat (16) @(posedge core_clk);
		arst_n <= 1'b1;
		@(negedge core_clk);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge core_clk);
		n_errors++;
		print_verdict();
	end
	initial begin
		rst();
		chk("state", ST_IDLE, state_ff);
		chk("rca", RCA_DEFAULT, rca_ff);
		chk("dsr", DSR_DEFAULT, dsr_ff);
		chk("drive", 32'h0, push_pull_ff);
		chk("alt", 32'h0, alt_mode_ff);
		chk("oe", 32'h0, {link.rsp_oe, link.id_oe});
		chk("ident", 32'h1, ident_mode_ff);
		chk("irq", 32'h0, irq_mode_ff);
		$display("test reset done");
		send(CMD_SELECT, {MY_RCA, 16'h0000}, 1'b0);
		chk("rsp", 32'h0, done_rsp_ff);
		chk("state", ST_IDLE, state_ff);
		send(CMD_OP_COND, 32'h0, 1'b0);
		chk("busy", 32'h1, busy_seen);
		chk("ready", {8'h80, OCR_DEFAULT}, done_data_ff);
		chk("state", ST_IDLE, state_ff);
		for (i = 0; i < 20 && state_ff !== ST_READY; i++) begin
			send(CMD_OP_COND, {8'h00, OCR_DEFAULT}, 1'b0);
		end
		chk("ready", {8'h80, OCR_DEFAULT}, done_data_ff);
		chk("state", ST_READY, state_ff);
		send(CMD_OP_COND, {8'h00, 24'h800000}, 1'b0);
		chk("window", OCR_DEFAULT, window_ff);
		$display("test voltage done");
		send(CMD_ID_BCAST, 32'h0, 1'b0);
		chk("id", CID_DEFAULT, done_data_ff[15:0]);
		chk("wire", CID_DEFAULT, id_shift);
		chk("state", ST_IDENT, state_ff);
		chk("drive", 32'h0, push_pull_ff);
		send(CMD_ASSIGN_ADDR, {MY_RCA, 16'h0000}, 1'b0);
		chk("arsp", {MY_RCA, 16'h0000}, done_data_ff);
		chk("rca", MY_RCA, rca_ff);
		chk("state", ST_STBY, state_ff);
		chk("drive", 32'h1, push_pull_ff);
		send(CMD_ID_BCAST, 32'h0, 1'b0);
		chk("rsp", 32'h0, done_rsp_ff);
		chk("ident", 32'h0, ident_mode_ff);
		send(CMD_SET_DRIVER, {16'h00a5, 16'h0000}, 1'b0);
		chk("rsp", 32'h0, done_rsp_ff);
		chk("dsr", 32'h0000_00a5, dsr_ff);
		$display("test identify done");
		send(CMD_STATUS, {16'h0077, 16'h0000}, 1'b0);
		chk("rsp", 32'h0, done_rsp_ff);
		send(CMD_STATUS, {MY_RCA, 16'h0000}, 1'b0);
		chk("status", {21'h0, ST_STBY}, done_data_ff);
		send(CMD_IRQ_MODE, 32'h0, 1'b0);
		chk("rsp", 32'h1, done_rsp_ff);
		chk("irq_rsp", {MY_RCA, 16'h0000}, done_data_ff);
		chk("state", ST_STBY, state_ff);
		chk("irq", 32'h0, irq_mode_ff);
		$display("test irq done");
		send(CMD_SELECT, {MY_RCA, 16'h0000}, 1'b0);
		chk("state", ST_TRAN, state_ff);
		send(CMD_READ_BLK, 32'h0, 1'b0);
		chk("state", ST_DATA, state_ff);
		chk("drive", 32'h1, push_pull_ff);
		send(CMD_STOP, 32'h0, 1'b0);
		chk("state", ST_TRAN, state_ff);
		send(CMD_WRITE_BLK, 32'h0, 1'b0);
		chk("state", ST_RCV, state_ff);
		send(CMD_STOP, 32'h0, 1'b0);
		chk("state", ST_PRG, state_ff);
		chk("drive", 32'h1, push_pull_ff);
		repeat (8) @(negedge core_clk);
		chk("state", ST_TRAN, state_ff);
		send(CMD_GO_INACTIVE, {MY_RCA, 16'h0000}, 1'b0);
		chk("state", ST_INACTIVE, state_ff);
		chk("drive", 32'h0, push_pull_ff);
		send(CMD_SOFT_RESET, 32'h0, 1'b0);
		chk("state", ST_INACTIVE, state_ff);
		send(CMD_SOFT_RESET, 32'h0, 1'b1);
		chk("state", ST_IDLE, state_ff);
		chk("alt", 32'h1, alt_mode_ff);
		chk("rca", RCA_DEFAULT, rca_ff);
		send(CMD_SOFT_RESET, 32'h0, 1'b0);
		chk("alt", 32'h0, alt_mode_ff);
		chk("window", 32'h0, window_ff);
		chk("dsr", DSR_DEFAULT, dsr_ff);
		$display("test mode done");
		for (i = 0; i < 20 && state_ff !== ST_INACTIVE; i++) begin
			send(CMD_OP_COND, {8'h00, BAD_WIN}, 1'b0);
		end
		chk("state", ST_INACTIVE, state_ff);
		rst();
		chk("state", ST_IDLE, state_ff);
		$display("test deactivate done");
		print_verdict();
	end
endmodule
